// ### fcd_dma.sv
// Behaviour
// RQ1: two-channel mode: ack-low output alone names channel 0 or 1.
// RQ2: peripheral requests a transfer by driving its request line high.
// RQ3: halt steal/first burst byte: sample all, serve winner, hold till done.
// RQ4: later burst bytes: active request sampled, byte moves only when high.
// RQ5: active-low strobe acknowledges peripheral and acts as valid address.
// RQ6: address steps per byte: up when setup bit 3 low, down when high.
// RQ7: 16-bit byte count, decremented at the start of each cycle; the code decrements it as the byte moves, at the end of the strobe cycle.
// RQ8: setup bit 0 gives direction, driven onto read/write during transfers.
// RQ9: setup bits 2:1: halt steal, halt burst, three-state steal; 11 illegal.
// RQ10: busy bit sets at start, clears after end output low one cycle.
// RQ11: end flag sets as busy clears, clears on host read of setup.
// RQ12: request-enable bits 0-3 gate recognition of each channel's request.
// RQ13: rotate bit low gives fixed priority 0,1,2,3.
// RQ14: rotate bit high moves served channel to lowest priority.
// RQ15: interrupt-enable bits 0-3 unmask each channel's end interrupt.
// RQ16: interrupt flag sets on enabled end, clears reading causing setup.
// RQ17: chain copies channel 3 address/count to selected channel after zero.
// RQ18: software keeps channel 3 idle while chaining is enabled.
// RQ19: chain bit 3 high: shared pin is select in host, ack-high in DMA.
// RQ20: reset clears all but address and count registers.
// RQ21: software loads a channel before enabling its request.
// RQ22: three-state steal: stretch request low, grant, one byte, release.
// RQ23: halt steal: halt request low, one byte once granted, release.
// RQ24: halt burst: keep halted until count reaches zero, then release.
// RQ25: enabled channel drives end/interrupt output low after final cycle.
// RQ26: in halt modes grant comes from processor bus-available.
// RQ27: illegal mode never starts; illegal chain select copies nothing.
`timescale 1ns/10ps
`default_nettype none
module fcd_dma
   import fcd_pkg::*;
#(
   parameter int NCH  = 4,
   parameter int AW   = 16,
   parameter int BUFD = 2
) (
   input  wire logic          sys_clk,
   input  wire logic          reset,
   input  wire logic          reset_n,
   input  wire logic [4:0]    reg_addr,
   input  wire logic          reg_cs_n_in,
   input  wire logic          reg_rd,
   input  wire logic          reg_wr,
   input  wire logic [7:0]    reg_wdata,
   output logic      [7:0]    reg_rdata,
   output logic               reg_rdata_oe,
   input  wire logic [NCH-1:0] channel_request_in,
   input  wire logic          bus_grant_in,
   output logic               clock_stretch_request_n,
   output logic               processor_halt_request_n,
   output logic               transfer_strobe_n,
   output logic               channel_ack_low_bit,
   output logic               select_or_channel_ack_high_bit,
   output logic               select_or_channel_ack_high_bit_oe,
   output logic               interrupt_or_block_end_n,
   output logic [AW-1:0]      dma_addr,
   output logic               dma_addr_oe,
   output logic               dma_rw,
   output logic               dma_rw_oe,
   output logic [1:0]         evt_chan,
   output logic [AW-1:0]      evt_addr,
   output logic               evt_valid,
   input  wire logic          evt_ready
);
   fcd_state_t state_ff, nxt_state;
   logic [AW-1:0] addr_ff  [NCH];
   logic [AW-1:0] cnt_ff   [NCH];
   logic [7:0]    setup_ff [NCH];
   logic [7:0]    prio_ff, irqc_ff, chain_ff;
   logic [1:0]    cur_ff, irq_src_ff;
   logic [1:0]    rank_ff [NCH];      // 0 = highest priority
   logic [NCH-1:0] req_sy_ff;
   logic [NCH-1:0] rq_a_ff, rq_b_ff, rq_c_ff;
   logic [2:0]    gr_ff;
   logic          grant_ff;
   logic          chain_pend_ff;
   logic          end_irq_ff;

   // Pin synchronisers: three stages, a change counts when stages two and
   // three agree so a runt glitch never starts a cycle
   always_ff @(posedge sys_clk) begin
      rq_a_ff <= channel_request_in;
      rq_b_ff <= rq_a_ff;
      rq_c_ff <= rq_b_ff;
      gr_ff   <= {gr_ff[1:0], bus_grant_in};
   end
   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_rq
         always_ff @(posedge sys_clk) begin
            if (reset)
               req_sy_ff[g] <= 1'b0;
            else if (rq_b_ff[g] == rq_c_ff[g])
               req_sy_ff[g] <= rq_b_ff[g]; // RQ2
         end
      end
   endgenerate
   always_ff @(posedge sys_clk) begin
      if (reset)
         grant_ff <= 1'b0;
      else if (gr_ff[1] == gr_ff[2])
         grant_ff <= gr_ff[1]; // RQ26
   end

   // Host access decode; writes land only while no transfer is running
   wire host_sel  = ~reg_cs_n_in & (state_ff == FCD_IDLE);
   wire host_wr   = host_sel & reg_wr;
   wire host_rd   = host_sel & reg_rd;
   wire is_ac     = reg_addr <= ADDR_BASE_LAST;
   wire is_ctrl   = reg_addr[4:2] == CTRL_BASE[4:2];
   wire [1:0] ac_ch  = reg_addr[3:2];
   wire [1:0] ct_ch  = reg_addr[1:0];
   wire ctrl_rd   = host_rd & is_ctrl;

   // Enabled request vector and priority pick
   wire [NCH-1:0] req_ok;
   generate
      for (g = 0; g < NCH; g++) begin : g_ok
         assign req_ok[g] = req_sy_ff[g] & prio_ff[g] // RQ12
            & (setup_ff[g][CS_MODE+:2] != MODE_BAD) // RQ27
            & ~setup_ff[g][CS_END];
      end
   endgenerate
   logic [1:0] pick;
   logic       pick_ok;
   logic [1:0] best_rank;
   always_comb begin
      pick = 2'h0;
      pick_ok = 1'b0;
      best_rank = 2'h3;
      for (int i = 0; i < NCH; i++) begin
         if (req_ok[i] && (!pick_ok || rank_ff[i] < best_rank)) begin
            pick = 2'(i); // RQ13
            best_rank = rank_ff[i];
            pick_ok = 1'b1;
         end
      end
   end

   wire [1:0] cur_mode = setup_ff[cur_ff][CS_MODE+:2];
   wire       cur_last = cnt_ff[cur_ff] == 16'h0001;
   wire       buf_ready;
   // One byte moves on a granted cycle; the buffer stalls it when full
   wire xfer_go  = (state_ff == FCD_XFER) & buf_ready;
   wire done_blk = xfer_go & cur_last;

   // Transfer sequencer
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         // A new request waits until the previous grant has dropped, so a
         // stale grant never strobes a bus that nobody handed over
         FCD_IDLE: if (pick_ok && !grant_ff) nxt_state = FCD_REQ; // RQ3
         FCD_REQ:  if (grant_ff) nxt_state = FCD_XFER; // RQ22
         FCD_XFER:
            if (xfer_go) begin
               if (cur_last)
                  nxt_state = FCD_END; // RQ24
               else if (cur_mode == MODE_HBURST)
                  nxt_state = FCD_WAIT;
               else
                  nxt_state = FCD_IDLE; // RQ23
            end
         // Later burst bytes wait for the active request only
         FCD_WAIT: if (req_sy_ff[cur_ff]) nxt_state = FCD_XFER; // RQ4
         FCD_END:  nxt_state = FCD_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (reset)
         state_ff <= FCD_IDLE;
      else
         state_ff <= nxt_state;
   end

   // Channel latch; requests are resampled only from idle, so not during a burst but before each steal byte
   always_ff @(posedge sys_clk) begin
      if (reset)
         cur_ff <= 2'h0;
      else if (state_ff == FCD_IDLE && nxt_state == FCD_REQ)
         cur_ff <= pick; // RQ3
   end

   // Rotating rank table
   generate
      for (g = 0; g < NCH; g++) begin : g_rank
         always_ff @(posedge sys_clk) begin
            if (reset || !prio_ff[PR_ROT])
               rank_ff[g] <= 2'(g); // RQ13
            else if (xfer_go && g == cur_ff)
               rank_ff[g] <= 2'h3; // RQ14
            else if (xfer_go && rank_ff[g] > rank_ff[cur_ff])
               rank_ff[g] <= rank_ff[g] - 2'h1; // RQ14
         end
      end
   endgenerate

   // Address and count registers; not reset, chain copy, host byte writes or transfer
   wire chain_fire = chain_pend_ff & chain_ff[DC_EN]
      & (chain_ff[DC_SEL+:2] != CHAIN_BAD); // RQ27
   generate
      for (g = 0; g < NCH; g++) begin : g_ac
         wire wr_here = host_wr & is_ac & (ac_ch == g);
         always_ff @(posedge sys_clk) begin
            if (chain_fire && chain_ff[DC_SEL+:2] == g) begin
               addr_ff[g] <= addr_ff[3]; // RQ17
               cnt_ff[g]  <= cnt_ff[3];
            end else if (xfer_go && cur_ff == g) begin
               cnt_ff[g] <= cnt_ff[g] - 16'h0001; // RQ7
               if (setup_ff[g][CS_DOWN])
                  addr_ff[g] <= addr_ff[g] - 16'h0001; // RQ6
               else
                  addr_ff[g] <= addr_ff[g] + 16'h0001; // RQ6
            end else if (wr_here) begin
               unique case (reg_addr[1:0])
                  2'h0: addr_ff[g][15:8] <= reg_wdata;
                  2'h1: addr_ff[g][7:0]  <= reg_wdata;
                  2'h2: cnt_ff[g][15:8]  <= reg_wdata;
                  2'h3: cnt_ff[g][7:0]   <= reg_wdata;
               endcase
            end
         end
      end
   endgenerate

   // Chain copy is taken the cycle after the count hits zero
   always_ff @(posedge sys_clk) begin
      if (reset)
         chain_pend_ff <= 1'b0;
      else
         chain_pend_ff <= done_blk; // RQ17
   end

   // Setup registers: busy and end bits are hardware owned
   generate
      for (g = 0; g < NCH; g++) begin : g_cs
         wire here   = cur_ff == g;
         wire wr_cs  = host_wr & is_ctrl & (ct_ch == g);
         wire rd_cs  = ctrl_rd & (ct_ch == g);
         wire set_bz = state_ff == FCD_REQ & here;
         wire fin    = state_ff == FCD_END & here;
         always_ff @(posedge sys_clk) begin
            if (reset) begin
               setup_ff[g] <= REG_RST; // RQ20
            end else begin
               if (wr_cs)
                  setup_ff[g][3:0] <= reg_wdata[3:0];
               if (set_bz)
                  setup_ff[g][CS_BUSY] <= 1'b1; // RQ10
               else if (fin)
                  setup_ff[g][CS_BUSY] <= 1'b0; // RQ10
               // Set wins over a read in the same cycle
               if (fin)
                  setup_ff[g][CS_END] <= 1'b1; // RQ11
               else if (rd_cs)
                  setup_ff[g][CS_END] <= 1'b0; // RQ11
            end
         end
      end
   endgenerate

   // Block-end pulse: low for the cycle after the last byte
   wire irq_set = (state_ff == FCD_END) & irqc_ff[cur_ff]; // RQ15
   always_ff @(posedge sys_clk) begin
      if (reset)
         end_irq_ff <= 1'b0;
      else
         end_irq_ff <= done_blk & irqc_ff[cur_ff]; // RQ25
   end

   // Shared registers
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         prio_ff    <= REG_RST; // RQ20
         irqc_ff    <= REG_RST;
         chain_ff   <= REG_RST;
         irq_src_ff <= 2'h0;
      end else begin
         if (host_wr && reg_addr == PRIO_ADDR)
            prio_ff <= {reg_wdata[7], 3'h0, reg_wdata[3:0]};
         if (host_wr && reg_addr == CHAIN_ADDR)
            chain_ff <= {4'h0, reg_wdata[3:0]};
         if (host_wr && reg_addr == IRQC_ADDR)
            irqc_ff[3:0] <= reg_wdata[3:0];
         if (irq_set) begin
            irqc_ff[IC_FLAG] <= 1'b1; // RQ16
            irq_src_ff <= cur_ff;
         end else if (ctrl_rd && ct_ch == irq_src_ff)
            irqc_ff[IC_FLAG] <= 1'b0; // RQ16
      end
   end

   // Host read mux, drivers on only for a selected read
   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = 8'h00;
      if (is_ac)
         unique case (reg_addr[1:0])
            2'h0: rd_mux = addr_ff[ac_ch][15:8];
            2'h1: rd_mux = addr_ff[ac_ch][7:0];
            2'h2: rd_mux = cnt_ff[ac_ch][15:8];
            2'h3: rd_mux = cnt_ff[ac_ch][7:0];
         endcase
      else if (is_ctrl)
         rd_mux = setup_ff[ct_ch];
      else if (reg_addr == PRIO_ADDR)
         rd_mux = prio_ff;
      else if (reg_addr == IRQC_ADDR)
         rd_mux = irqc_ff;
      else if (reg_addr == CHAIN_ADDR)
         rd_mux = chain_ff;
   end
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         reg_rdata    <= 8'h00;
         reg_rdata_oe <= 1'b0;
      end else begin
         reg_rdata    <= rd_mux;
         reg_rdata_oe <= host_rd;
      end
   end

   // Request, strobe and acknowledge pins
   wire in_req  = state_ff == FCD_REQ || state_ff == FCD_XFER;
   wire is_tsc  = cur_mode == MODE_TSTEAL; // RQ9
   wire in_dma  = state_ff != FCD_IDLE;
   assign clock_stretch_request_n  = ~(in_req & is_tsc); // RQ22
   // Halt held through burst waits until the last byte has moved
   assign processor_halt_request_n =
      ~((in_req | state_ff == FCD_WAIT) & ~is_tsc); // RQ23
   assign transfer_strobe_n = ~xfer_go; // RQ5
   assign channel_ack_low_bit = cur_ff[0]; // RQ1
   assign select_or_channel_ack_high_bit = cur_ff[1]; // RQ19
   assign select_or_channel_ack_high_bit_oe =
      chain_ff[DC_FOUR] & in_dma; // RQ19
   assign interrupt_or_block_end_n = ~end_irq_ff; // RQ25
   assign dma_addr    = addr_ff[cur_ff];
   assign dma_addr_oe = xfer_go;
   assign dma_rw      = setup_ff[cur_ff][CS_DIR]; // RQ8
   assign dma_rw_oe   = xfer_go; // RQ8

   // Two-entry buffer of moved-byte records toward the consumer
   logic [AW+1:0] buf_ff [BUFD];
   logic [1:0]    wp_ff, rp_ff;
   wire buf_full  = (wp_ff - rp_ff) == 2'(BUFD);
   wire buf_empty = wp_ff == rp_ff;
   assign buf_ready = ~buf_full;
   wire push = xfer_go;
   wire pop  = evt_valid & evt_ready;
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         wp_ff <= 2'h0;
         rp_ff <= 2'h0;
      end else begin
         if (push)
            wp_ff <= wp_ff + 2'h1;
         if (pop)
            rp_ff <= rp_ff + 2'h1;
      end
      if (push)
         buf_ff[wp_ff[0]] <= {cur_ff, addr_ff[cur_ff]};
   end
   assign evt_valid = ~buf_empty;
   assign evt_chan  = buf_ff[rp_ff[0]][AW+:2];
   assign evt_addr  = buf_ff[rp_ff[0]][AW-1:0];
endmodule // fcd_dma
`default_nettype wire

// ### fcd_dma_checker.sv
`timescale 1ns/10ps
`default_nettype none
module fcd_dma_checker #(
   parameter int AW = 16
) (
   input wire logic          sys_clk,
   input wire logic          reset,
   input wire logic          transfer_strobe_n,
   input wire logic          clock_stretch_request_n,
   input wire logic          processor_halt_request_n,
   input wire logic          interrupt_or_block_end_n,
   input wire logic [AW-1:0] dma_addr,
   input wire logic          dma_addr_oe,
   input wire logic          dma_rw_oe,
   input wire logic          channel_ack_low_bit,
   input wire logic [1:0]    evt_chan,
   input wire logic [AW-1:0] evt_addr,
   input wire logic          evt_valid,
   input wire logic          evt_ready
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   // Reset must leave every request and strobe released
   a_reset_quiet: assert property (disable iff (1'b0) reset |=>
      transfer_strobe_n && processor_halt_request_n
      && clock_stretch_request_n && !evt_valid)
      else $error("outputs active after reset");
   a_strobe_vma: assert property (!transfer_strobe_n |-> dma_addr_oe)
      else $error("strobe without address drive");
   a_rw_window: assert property (dma_rw_oe == dma_addr_oe)
      else $error("read/write drive outside strobe");
   // Only one kind of bus request may be pending at a time
   a_req_mutex: assert property (clock_stretch_request_n
      || processor_halt_request_n)
      else $error("stretch and halt requested together");
   a_end_pulse: assert property ($fell(interrupt_or_block_end_n) |=>
      interrupt_or_block_end_n)
      else $error("block end pulse not one cycle");
   a_push_strobe: assert property (!transfer_strobe_n |=> evt_valid)
      else $error("moved byte not buffered");
   // A stalled consumer must see the same word until it takes it
   a_evt_hold: assert property (evt_valid && !evt_ready |=>
      evt_valid && $stable(evt_addr) && $stable(evt_chan))
      else $error("buffered word changed under stall");
   a_evt_capture: assert property (!transfer_strobe_n && !evt_valid
      |=> evt_addr == $past(dma_addr)
      && evt_chan[0] == $past(channel_ack_low_bit))
      else $error("buffered word differs from bus cycle");
   c_halt: cover property ($fell(processor_halt_request_n));
   c_stretch: cover property ($fell(clock_stretch_request_n));
   c_stall: cover property (evt_valid && !evt_ready ##1 evt_ready);
endmodule // fcd_dma_checker
bind fcd_dma fcd_dma_checker #(.AW(AW)) u_chk (.sys_clk, .reset,
   .transfer_strobe_n, .clock_stretch_request_n,
   .processor_halt_request_n, .interrupt_or_block_end_n, .dma_addr,
   .dma_addr_oe, .dma_rw_oe, .channel_ack_low_bit, .evt_chan,
   .evt_addr, .evt_valid, .evt_ready);
`default_nettype wire

// ### fcd_periph_model.sv
`timescale 1ns/10ps
`default_nettype none
module fcd_periph_model (
   input  wire logic       sys_clk,
   input  wire logic       reset,
   input  wire logic [3:0] want,
   input  wire logic       stall,
   input  wire logic       halt_n,
   input  wire logic       stretch_n,
   output logic [3:0]      req,
   output logic            grant,
   output logic            ready
);
   logic [1:0] dly_ff;
   // Each controller holds its request high while it wants data
   assign req = want;
   // Grant answers either request late, as a halted processor would
   always_ff @(posedge sys_clk) begin
      if (reset || (halt_n && stretch_n))
         dly_ff <= 2'h0;
      else if (dly_ff != 2'h3)
         dly_ff <= dly_ff + 2'h1;
   end
   assign grant = (dly_ff == 2'h3);
   // Stalling consumer lets the buffer fill up
   assign ready = !stall;
endmodule // fcd_periph_model
`default_nettype wire

// ### fcd_pkg.sv
`default_nettype none
package fcd_pkg;
   // Register index on the 5-bit host address
   localparam logic [4:0] ADDR_BASE_LAST = 5'h0F;   // 0x0..0xF address/count
   localparam logic [4:0] CTRL_BASE      = 5'h10;   // 0x10..0x13 channel setup
   localparam logic [4:0] PRIO_ADDR      = 5'h14;
   localparam logic [4:0] IRQC_ADDR      = 5'h15;
   localparam logic [4:0] CHAIN_ADDR     = 5'h16;
   // Channel setup bit positions
   localparam int CS_DIR  = 0;
   localparam int CS_MODE = 1;   // Two bits, 2:1
   localparam int CS_DOWN = 3;
   localparam int CS_BUSY = 6;
   localparam int CS_END  = 7;
   // Shared register bit positions
   localparam int PR_ROT  = 7;
   localparam int IC_FLAG = 7;
   localparam int DC_EN   = 0;
   localparam int DC_SEL  = 1;   // Two bits, 2:1
   localparam int DC_FOUR = 3;
   localparam logic [7:0] REG_RST = 8'h00;
   // Mode codes in setup bits 2:1
   localparam logic [1:0] MODE_HSTEAL = 2'h0;
   localparam logic [1:0] MODE_HBURST = 2'h1;
   localparam logic [1:0] MODE_TSTEAL = 2'h2;
   localparam logic [1:0] MODE_BAD    = 2'h3;
   localparam logic [1:0] CHAIN_BAD   = 2'h3;
   typedef enum logic [2:0] {
      FCD_IDLE, FCD_REQ, FCD_XFER, FCD_WAIT, FCD_END
   } fcd_state_t;
endpackage
`default_nettype wire

// ### test_four_channel_byte_dma.sv
`timescale 1ns/10ps
`default_nettype none
module test_four_channel_byte_dma;
   import fcd_pkg::*;
   logic        sys_clk, reset, cs_n, rd, wr, stall, ready, grant;
   logic [4:0]  addr;
   logic [7:0]  wdata, rdata;
   logic [3:0]  want, req;
   logic        rd_oe, str_n, halt_n, stb_n, ack_lo, ack_hi, ackb_oe;
   logic        end_n, a_oe, rw, rw_oe, ev_v;
   logic [15:0] dma_a, ev_a;
   logic [1:0]  ev_c;
   logic [17:0] evq[$];
   logic        saw_rw, saw_str, saw_ackb, saw_end;
   int          error_cnt, samples_checked, cyc;

   fcd_dma dut (.sys_clk(sys_clk), .reset(reset), .reset_n(1'b1),
      .reg_addr(addr), .reg_cs_n_in(cs_n), .reg_rd(rd), .reg_wr(wr),
      .reg_wdata(wdata), .reg_rdata(rdata), .reg_rdata_oe(rd_oe),
      .channel_request_in(req), .bus_grant_in(grant),
      .clock_stretch_request_n(str_n),
      .processor_halt_request_n(halt_n), .transfer_strobe_n(stb_n),
      .channel_ack_low_bit(ack_lo),
      .select_or_channel_ack_high_bit(ack_hi),
      .select_or_channel_ack_high_bit_oe(ackb_oe),
      .interrupt_or_block_end_n(end_n), .dma_addr(dma_a),
      .dma_addr_oe(a_oe), .dma_rw(rw), .dma_rw_oe(rw_oe),
      .evt_chan(ev_c), .evt_addr(ev_a), .evt_valid(ev_v),
      .evt_ready(ready));
   fcd_periph_model peer (.sys_clk(sys_clk), .reset(reset), .want(want),
      .stall(stall), .halt_n(halt_n), .stretch_n(str_n), .req(req),
      .grant(grant), .ready(ready));

   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   task automatic give_verdict();
      $display("checked %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Watch the far side; a hang ends in the same verdict
   always @(posedge sys_clk) begin
      cyc++;
      if (ev_v && ready)
         evq.push_back({ev_c, ev_a});
      if (!stb_n)
         saw_rw = rw;
      if (!str_n)
         saw_str = 1'b1;
      // Only channel 1 is served with the pin driven, so its bit must be 0
      if (ackb_oe)
         saw_ackb = !ack_hi;
      if (!end_n)
         saw_end = 1'b1;
      if (cyc == 20000) begin
         error_cnt++;
         give_verdict();
      end
   end
   task automatic chk(input logic [17:0] got, input logic [17:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Host access: one edge with select and strobe held, then release
   task automatic wr8(input logic [4:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      addr = a;
      wdata = d;
      cs_n = 1'b0;
      wr = 1'b1;
      @(negedge sys_clk);
      cs_n = 1'b1;
      wr = 1'b0;
   endtask
   task automatic rd8(input logic [4:0] a, input logic [7:0] e);
      @(negedge sys_clk);
      addr = a;
      cs_n = 1'b0;
      rd = 1'b1;
      @(negedge sys_clk);
      cs_n = 1'b1;
      rd = 1'b0;
      chk({9'h000, rd_oe, rdata}, {10'h001, e});
   endtask
   task automatic load(input logic [1:0] ch, input logic [15:0] a,
                       input logic [15:0] n, input logic [7:0] s);
      wr8({1'b0, ch, 2'h0}, a[15:8]);
      wr8({1'b0, ch, 2'h1}, a[7:0]);
      wr8({1'b0, ch, 2'h2}, n[15:8]);
      wr8({1'b0, ch, 2'h3}, n[7:0]);
      wr8(CTRL_BASE + {3'h0, ch}, s);
   endtask
   // Bounded by the global cycle ceiling; then let the block end settle
   task automatic run(input logic [3:0] w, input int n);
      want = w;
      while (evq.size() < n)
         @(negedge sys_clk);
      want = 4'h0;
      repeat (8) @(negedge sys_clk);
   endtask
   task automatic ev(input logic [1:0] c, input logic [15:0] a);
      chk(evq.size() != 0 ? evq.pop_front() : 18'h3FFFF, {c, a});
   endtask
   task automatic prio_run(input logic rot, input logic [17:0] e [4]);
      load(2'h0, 16'h0100, 16'h0002, 8'h00);
      load(2'h2, 16'h0200, 16'h0002, 8'h00);
      wr8(PRIO_ADDR, {rot, 7'h05});
      run(4'h5, 4);
      foreach (e[i])
         chk(evq.pop_front(), e[i]);
      rd8(CTRL_BASE, 8'h80);
      rd8(CTRL_BASE + 5'h02, 8'h80);
   endtask

   initial begin
      reset = 1'b1;
      cs_n = 1'b1;
      {rd, wr, addr, wdata, want, stall} = 20'h0;
      {saw_rw, saw_str, saw_ackb, saw_end} = 4'h0;
      error_cnt = 0;
      samples_checked = 0;
      cyc = 0;
      repeat (2) @(negedge sys_clk);
      reset = 1'b0;
      // Reset values, with a write to an unmapped place first
      wr8(5'h17, 8'hFF);
      for (int i = 16; i < 23; i++)
         rd8(5'(i), REG_RST);
      $display("test reset_values done");
      // Halt steal, two bytes upward, interrupt enabled
      load(2'h0, 16'h1234, 16'h0002, 8'h00);
      wr8(IRQC_ADDR, 8'h01);
      wr8(PRIO_ADDR, 8'h01);
      run(4'h1, 2);
      ev(2'h0, 16'h1234);
      ev(2'h0, 16'h1235);
      chk({17'h0, saw_end}, 18'h1);
      rd8(IRQC_ADDR, 8'h81);
      rd8(CTRL_BASE, 8'h80);
      rd8(IRQC_ADDR, 8'h01);
      rd8(CTRL_BASE, 8'h00);
      rd8(5'h01, 8'h36);
      rd8(5'h03, 8'h00);
      $display("test halt_steal done");
      // Halt burst downward, consumer stalls, interrupt masked
      stall = 1'b1;
      load(2'h1, 16'h0010, 16'h0003, 8'h0B);
      wr8(PRIO_ADDR, 8'h02);
      want = 4'h2;
      repeat (40) @(negedge sys_clk);
      // Two bytes fill the buffer; the third waits with the halt held
      chk({ev_c, ev_a}, 18'h10010);
      chk({15'h0, ev_v, stb_n, halt_n}, 18'h6);
      stall = 1'b0;
      run(4'h2, 3);
      ev(2'h1, 16'h0010);
      ev(2'h1, 16'h000F);
      ev(2'h1, 16'h000E);
      chk({17'h0, saw_rw}, 18'h1);
      rd8(CTRL_BASE + 5'h01, 8'h8B);
      rd8(IRQC_ADDR, 8'h01);
      $display("test halt_burst done");
      // Fixed then rotating order between channels 0 and 2
      prio_run(1'b0, '{18'h00100, 18'h00101, 18'h20200, 18'h20201});
      prio_run(1'b1, '{18'h00100, 18'h20200, 18'h00101, 18'h20201});
      chk({17'h0, saw_ackb | saw_str}, 18'h0);
      $display("test priority done");
      // Three-state steal with chaining from channel 3 into channel 1
      load(2'h3, 16'hA000, 16'h0005, 8'h00);
      load(2'h1, 16'h0040, 16'h0001, 8'h04);
      wr8(CHAIN_ADDR, 8'h0B);
      wr8(PRIO_ADDR, 8'h02);
      run(4'h2, 1);
      ev(2'h1, 16'h0040);
      chk({16'h0, saw_str, saw_ackb}, 18'h3);
      rd8(5'h04, 8'hA0);
      rd8(5'h07, 8'h05);
      rd8(CTRL_BASE + 5'h01, 8'h84);
      wr8(CHAIN_ADDR, 8'h00);
      $display("test stretch_chain done");
      // Illegal mode code is never started
      load(2'h0, 16'h0300, 16'h0001, 8'h06);
      wr8(PRIO_ADDR, 8'h01);
      want = 4'h1;
      repeat (40) @(negedge sys_clk);
      chk({17'h0, halt_n}, {16'h0, evq.size() != 0, 1'b1});
      rd8(CTRL_BASE, 8'h06);
      want = 4'h0;
      $display("test illegal_mode done");
      give_verdict();
   end
endmodule // test_four_channel_byte_dma
`default_nettype wire
